//--- include/tv_out_pkg.sv
// Purpose: constants and types for the TV encoder output and VBI block
// Assumes: one 25 MHz clock, registers on APB, one word per register
// Notes: offsets are byte addresses
// Contract
// - Composite is luma plus chroma, clamped at code limits, never wrapping.
// - Colour kill gives composite equal to luma, trap-filtered only when trap is on; chroma output only by blank.
// - Cr/Cb interpolated fourfold, matrixed with luma into R, G, B.
// - Caption: run-in, start bit, two bytes per field on luma path.
// - Caption bytes double-buffered; writes never corrupt bytes in flight.
// - First byte register sent first, then second, each LSB first.
// - Caption line per field comes from a programmable line register.
// - Caption wins over copy-management data on the same line.
// - Run-in and bits from a phase accumulator at 503.5 kbit/s.
// - Caption zero at 0 IRE code, one at 50 IRE code.
// - Two status bits flag caption loads that come too often.
// - Caption bytes become new only when the second byte is written.
// - No new bytes by window start: two odd-parity NULLs are sent.
// - Send 1, 0, then 20 host bits; host supplies the CRC.
// - Copy-management on lines 20 and 283 every field when enabled.
// - Copy data double-buffered, new when its last register is written.
// - Adjust request with direction 1 shortens the frame, then self-clears.
// - Adjust request with direction 0 lengthens the frame, then self-clears.
// - Output select 1: Y, C, two composites; 0: R, G, B, composite.
// - Disabled converter shows neutral: blank, no colour, or black.
package tv_out_pkg;
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_ADJ    = 8'h04;
	localparam logic [7:0]  REG_STAT   = 8'h08;
	localparam logic [7:0]  REG_CCL1   = 8'h0C;
	localparam logic [7:0]  REG_CCL2   = 8'h10;
	localparam logic [7:0]  REG_CC1A   = 8'h14;
	localparam logic [7:0]  REG_CC1B   = 8'h18;
	localparam logic [7:0]  REG_CC2A   = 8'h1C;
	localparam logic [7:0]  REG_CC2B   = 8'h20;
	localparam logic [7:0]  REG_CGA    = 8'h24;
	localparam logic [7:0]  REG_CGB    = 8'h28;
	localparam logic [7:0]  REG_CGC    = 8'h2C;
	localparam int          C_CAP_EN1  = 0;
	localparam int          C_CAP_EN2  = 1;
	localparam int          C_KILL     = 2;
	localparam int          C_OSEL     = 3;
	localparam int          C_CGMS     = 4;
	localparam int          C_TRAP     = 5;
	localparam int          C_CBLK     = 6;
	localparam int          C_DDIS     = 8;
	localparam int          A_REQ      = 0;
	localparam int          A_DIR      = 1;
	localparam logic [12:0] CTRL_RST   = 13'h0008;
	localparam logic [8:0]  CCL1_RST   = 9'h015;
	localparam logic [8:0]  CCL2_RST   = 9'h11C;
	localparam logic [8:0]  CG_LINE1   = 9'h014;
	localparam logic [8:0]  CG_LINE2   = 9'h11B;
	localparam logic [8:0]  BLANK_CODE = 9'h080;
	localparam logic [8:0]  IRE50_CODE = 9'h140;
	localparam logic [8:0]  BLACK_CODE = 9'h000;
	localparam logic [8:0]  CZERO_CODE = 9'h100;
	localparam logic [7:0]  NULL_ODD   = 8'h80;
	localparam logic [2:0]  START_SEQ  = 3'h4;
	localparam logic [1:0]  CG_REF     = 2'h1;
	localparam logic [2:0]  RUNIN_CYC  = 3'h7;
	localparam logic [4:0]  CC_BITS    = 5'h13;
	localparam logic [4:0]  CG_BITS    = 5'h16;
	localparam int          CLK_HZ     = 25000000;
	localparam int          CC_RATE_HZ = 503500;
	localparam int          CG_RATE_HZ = 447443;
	localparam logic [23:0] CC_INC     = 24'((64'(CC_RATE_HZ) << 24) / 64'(CLK_HZ));
	localparam logic [23:0] CG_INC     = 24'((64'(CG_RATE_HZ) << 24) / 64'(CLK_HZ));
	localparam int          WIN_NS     = 10500;
	localparam int          WIN_CYC    = (WIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int          KR_CR      = 359;
	localparam int          KG_CB      = 88;
	localparam int          KG_CR      = 183;
	localparam int          KB_CB      = 454;
	typedef struct packed {
		logic [8:0]        luma;
		logic [8:0]        luma_trap;
		logic signed [8:0] chroma;
		logic [7:0]        cr;
		logic [7:0]        cb;
	} vid_in_t;
	typedef struct packed {
		logic [3:0][8:0] code;
	} dac_out_t;
	typedef enum {ST_IDLE, ST_WAIT, ST_SEND} vbi_st_t;
endpackage

//--- hw/tv_out_encoder.sv
// Purpose: composite/RGB output stage with caption and copy-data insertion
// Assumes: video and line timing come from logic on pclk
// Notes: frame length changes are requested of the timing generator
`timescale 1ns/1ps
`default_nettype none
module tv_out_encoder #(
	parameter int WIN_DLY = tv_out_pkg::WIN_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic [7:0]          paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire tv_out_pkg::vid_in_t vid,
	input  wire logic                cbcr_stb,
	input  wire logic                line_start,
	input  wire logic [8:0]          line_num,
	input  wire logic                field_two,
	input  wire logic                frame_end,
	output tv_out_pkg::dac_out_t     dac,
	output logic                     frame_shorten,
	output logic                     frame_lengthen
);
	logic [12:0]          ctrl_r;
	logic                 req_r;
	logic                 dir_r;
	logic [1:0]           ov_r;
	logic [8:0]           ccl_r [2];
	logic [7:0]           stg_r [4];
	logic [1:0]           new_r;
	logic [19:0]          cg_stg_r;
	logic [19:0]          cg_sh_r;
	tv_out_pkg::vbi_st_t  st_r;
	logic [15:0]          dly_r;
	logic                 cc_mode_r;
	logic                 fld_r;
	logic [23:0]          acc_r;
	logic [21:0]          sh_r;
	logic [4:0]           cnt_r;
	logic [2:0]           runin_r;
	logic signed [8:0]    cr_prev_r;
	logic signed [8:0]    cr_cur_r;
	logic signed [8:0]    cb_prev_r;
	logic signed [8:0]    cb_cur_r;
	logic [1:0]           ph_r;
	logic                 wr;
	logic                 setup;
	logic                 cc_hit;
	logic                 cg_hit;
	logic                 win_go;
	logic                 consume;
	logic [24:0]          acc_nxt;
	logic                 tick;
	logic                 ins;
	logic [8:0]           vbi_code;
	logic [8:0]           lum_sel;
	logic [8:0]           comp_l;
	logic [8:0]           comp;
	logic signed [19:0]   sum;
	logic [8:0]           luma_o;
	logic [8:0]           chroma_o;
	logic signed [19:0]   cr_i;
	logic signed [19:0]   cb_i;
	logic [8:0]           r_c;
	logic [8:0]           g_c;
	logic [8:0]           b_c;
	tv_out_pkg::dac_out_t dac_nxt;
	logic [31:0]          rd_nxt;
	logic                 map_ok;
	logic [15:0]          cap_pair;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [8:0] sat9(input logic signed [19:0] v);
		if (v < 0)
			sat9 = 9'h000;
		else if (v > 20'sd511)
			sat9 = 9'h1FF;
		else
			sat9 = v[8:0];
	endfunction

	function automatic logic [19:0] rev20(input logic [19:0] d);
		for (int i = 0; i < 20; i++)
			rev20[i] = d[19 - i];
	endfunction

	// Zero-wait slave; write commits in the access phase only
	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite && pready;

	always_comb begin
		map_ok = 1'b1;
		rd_nxt = 32'h0000_0000;
		case (paddr)
			tv_out_pkg::REG_CTRL: rd_nxt = {19'h0, ctrl_r};
			tv_out_pkg::REG_ADJ:  rd_nxt = {30'h0, dir_r, req_r};
			tv_out_pkg::REG_STAT: rd_nxt = {28'h0, st_r != tv_out_pkg::ST_IDLE, req_r, ov_r};
			tv_out_pkg::REG_CCL1: rd_nxt = {23'h0, ccl_r[0]};
			tv_out_pkg::REG_CCL2: rd_nxt = {23'h0, ccl_r[1]};
			tv_out_pkg::REG_CC1A: rd_nxt = {24'h0, stg_r[0]};
			tv_out_pkg::REG_CC1B: rd_nxt = {24'h0, stg_r[1]};
			tv_out_pkg::REG_CC2A: rd_nxt = {24'h0, stg_r[2]};
			tv_out_pkg::REG_CC2B: rd_nxt = {24'h0, stg_r[3]};
			tv_out_pkg::REG_CGA:  rd_nxt = {28'h0, cg_stg_r[19:16]};
			tv_out_pkg::REG_CGB:  rd_nxt = {24'h0, cg_stg_r[15:8]};
			tv_out_pkg::REG_CGC:  rd_nxt = {24'h0, cg_stg_r[7:0]};
			default:              map_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
				pslverr <= !map_ok;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= tv_out_pkg::CTRL_RST;
			ccl_r[0] <= tv_out_pkg::CCL1_RST;
			ccl_r[1] <= tv_out_pkg::CCL2_RST;
		end else if (wr) begin
			if (hit(paddr, tv_out_pkg::REG_CTRL))
				ctrl_r <= pwdata[12:0];
			if (hit(paddr, tv_out_pkg::REG_CCL1))
				ccl_r[0] <= pwdata[8:0];
			if (hit(paddr, tv_out_pkg::REG_CCL2))
				ccl_r[1] <= pwdata[8:0];
		end
	end

	// Frame adjust: request waits for the frame end, then clears itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_r          <= 1'b0;
			dir_r          <= 1'b0;
			frame_shorten  <= 1'b0;
			frame_lengthen <= 1'b0;
		end else begin
			frame_shorten  <= req_r && frame_end && dir_r;
			frame_lengthen <= req_r && frame_end && !dir_r;
			if (req_r && frame_end)
				req_r <= 1'b0;
			if (wr && hit(paddr, tv_out_pkg::REG_ADJ) && pwdata[tv_out_pkg::A_REQ]) begin
				req_r <= 1'b1;
				dir_r <= pwdata[tv_out_pkg::A_DIR];
			end
		end
	end

	// Caption staging; a late consume never eats a same-cycle write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++)
				stg_r[i] <= 8'h00;
			new_r <= 2'h0;
			ov_r  <= 2'h0;
		end else begin
			if (wr && hit(paddr, tv_out_pkg::REG_STAT))
				ov_r <= ov_r & ~pwdata[1:0];
			if (consume)
				new_r[fld_r] <= 1'b0;
			if (wr && hit(paddr, tv_out_pkg::REG_CC1A))
				stg_r[0] <= pwdata[7:0];
			if (wr && hit(paddr, tv_out_pkg::REG_CC2A))
				stg_r[2] <= pwdata[7:0];
			if (wr && hit(paddr, tv_out_pkg::REG_CC1B)) begin
				stg_r[1] <= pwdata[7:0];
				new_r[0] <= 1'b1;
				if (new_r[0])
					ov_r[0] <= 1'b1;
			end
			if (wr && hit(paddr, tv_out_pkg::REG_CC2B)) begin
				stg_r[3] <= pwdata[7:0];
				new_r[1] <= 1'b1;
				if (new_r[1])
					ov_r[1] <= 1'b1;
			end
		end
	end

	// Copy data staging; only the last-register write moves a word to the shadow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cg_stg_r <= 20'h00000;
			cg_sh_r  <= 20'h00000;
		end else begin
			if (wr && hit(paddr, tv_out_pkg::REG_CGA))
				cg_stg_r[19:16] <= pwdata[3:0];
			if (wr && hit(paddr, tv_out_pkg::REG_CGB))
				cg_stg_r[15:8] <= pwdata[7:0];
			if (wr && hit(paddr, tv_out_pkg::REG_CGC)) begin
				cg_stg_r[7:0] <= pwdata[7:0];
				cg_sh_r       <= {cg_stg_r[19:8], pwdata[7:0]};
			end
		end
	end

	assign cc_hit = field_two ? (ctrl_r[tv_out_pkg::C_CAP_EN2] && line_num == ccl_r[1])
	                          : (ctrl_r[tv_out_pkg::C_CAP_EN1] && line_num == ccl_r[0]);
	assign cg_hit = ctrl_r[tv_out_pkg::C_CGMS] &&
	                line_num == (field_two ? tv_out_pkg::CG_LINE2 : tv_out_pkg::CG_LINE1);
	assign win_go  = st_r == tv_out_pkg::ST_WAIT && dly_r == 16'(WIN_DLY - 1);
	assign consume = win_go && cc_mode_r;
	assign acc_nxt = {1'b0, acc_r} + {1'b0, cc_mode_r ? tv_out_pkg::CC_INC : tv_out_pkg::CG_INC};
	assign tick    = acc_nxt[24];
	assign cap_pair = new_r[fld_r] ? {stg_r[{fld_r, 1'b1}], stg_r[{fld_r, 1'b0}]}
	                               : {tv_out_pkg::NULL_ODD, tv_out_pkg::NULL_ODD};

	// Bits leave LSB first; run-in is the accumulator's top bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= tv_out_pkg::ST_IDLE;
			dly_r     <= 16'h0000;
			cc_mode_r <= 1'b0;
			fld_r     <= 1'b0;
			acc_r     <= 24'h000000;
			sh_r      <= 22'h000000;
			cnt_r     <= 5'h00;
			runin_r   <= 3'h0;
		end else begin
			case (st_r)
				tv_out_pkg::ST_IDLE: begin
					if (line_start && (cc_hit || cg_hit)) begin
						st_r      <= tv_out_pkg::ST_WAIT;
						dly_r     <= 16'h0000;
						cc_mode_r <= cc_hit;
						fld_r     <= field_two;
					end
				end
				tv_out_pkg::ST_WAIT: begin
					dly_r <= dly_r + 16'h0001;
					if (win_go) begin
						st_r  <= tv_out_pkg::ST_SEND;
						acc_r <= 24'h000000;
						if (cc_mode_r) begin
							sh_r    <= {3'h0, cap_pair, tv_out_pkg::START_SEQ};
							cnt_r   <= tv_out_pkg::CC_BITS;
							runin_r <= tv_out_pkg::RUNIN_CYC;
						end else begin
							sh_r    <= {rev20(cg_sh_r), tv_out_pkg::CG_REF};
							cnt_r   <= tv_out_pkg::CG_BITS;
							runin_r <= 3'h0;
						end
					end
				end
				tv_out_pkg::ST_SEND: begin
					acc_r <= acc_nxt[23:0];
					if (tick) begin
						if (runin_r != 3'h0) begin
							runin_r <= runin_r - 3'h1;
						end else begin
							sh_r  <= {1'b0, sh_r[21:1]};
							cnt_r <= cnt_r - 5'h01;
							if (cnt_r == 5'h01)
								st_r <= tv_out_pkg::ST_IDLE;
						end
					end
				end
				default: st_r <= tv_out_pkg::ST_IDLE;
			endcase
		end
	end

	// Linear 4x interpolation; a simple ramp, not a sharp-cutoff filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cr_prev_r <= 9'sh000;
			cr_cur_r  <= 9'sh000;
			cb_prev_r <= 9'sh000;
			cb_cur_r  <= 9'sh000;
			ph_r      <= 2'h0;
		end else if (cbcr_stb) begin
			cr_prev_r <= cr_cur_r;
			cb_prev_r <= cb_cur_r;
			cr_cur_r  <= $signed({1'b0, vid.cr}) - 9'sh080;
			cb_cur_r  <= $signed({1'b0, vid.cb}) - 9'sh080;
			ph_r      <= 2'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
		end
	end

	always_comb begin
		ins      = st_r == tv_out_pkg::ST_SEND;
		vbi_code = ((runin_r != 3'h0) ? acc_r[23] : sh_r[0]) ?
		           tv_out_pkg::IRE50_CODE : tv_out_pkg::BLANK_CODE;
		lum_sel  = ctrl_r[tv_out_pkg::C_TRAP] ? vid.luma_trap : vid.luma;
		luma_o   = ins ? vbi_code : vid.luma;
		comp_l   = ins ? vbi_code : lum_sel;
		sum      = $signed({11'h000, comp_l}) + 20'(vid.chroma);
		comp     = ctrl_r[tv_out_pkg::C_KILL] ? comp_l : sat9(sum);
		chroma_o = ctrl_r[tv_out_pkg::C_CBLK] ? tv_out_pkg::CZERO_CODE
		                                      : {~vid.chroma[8], vid.chroma[7:0]};
		cr_i = 20'(cr_prev_r) + ((20'(cr_cur_r) - 20'(cr_prev_r)) * $signed({18'h0, ph_r}) >>> 2);
		cb_i = 20'(cb_prev_r) + ((20'(cb_cur_r) - 20'(cb_prev_r)) * $signed({18'h0, ph_r}) >>> 2);
		r_c  = sat9(20'($signed({11'h000, vid.luma})
		            + ((cr_i * tv_out_pkg::KR_CR) >>> 8)));
		g_c  = sat9(20'($signed({11'h000, vid.luma}) - ((cb_i * tv_out_pkg::KG_CB) >>> 8)
		            - ((cr_i * tv_out_pkg::KG_CR) >>> 8)));
		b_c  = sat9(20'($signed({11'h000, vid.luma})
		            + ((cb_i * tv_out_pkg::KB_CB) >>> 8)));
		if (ctrl_r[tv_out_pkg::C_OSEL]) begin
			dac_nxt.code = {comp, comp, chroma_o, luma_o};
			if (ctrl_r[tv_out_pkg::C_DDIS])
				dac_nxt.code[0] = tv_out_pkg::BLANK_CODE;
			if (ctrl_r[tv_out_pkg::C_DDIS + 1])
				dac_nxt.code[1] = tv_out_pkg::CZERO_CODE;
			if (ctrl_r[tv_out_pkg::C_DDIS + 2])
				dac_nxt.code[2] = tv_out_pkg::BLANK_CODE;
		end else begin
			dac_nxt.code = {comp, b_c, g_c, r_c};
			for (int i = 0; i < 3; i++)
				if (ctrl_r[tv_out_pkg::C_DDIS + i])
					dac_nxt.code[i] = tv_out_pkg::BLACK_CODE;
		end
		if (ctrl_r[tv_out_pkg::C_DDIS + 3])
			dac_nxt.code[3] = tv_out_pkg::BLANK_CODE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dac <= '{code: {4{tv_out_pkg::BLANK_CODE}}};
		else
			dac <= dac_nxt;
	end

	default clocking cb_clk @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_short_req;
		req_r && dir_r && frame_end;
	endsequence
	sequence s_long_req;
		req_r && !dir_r && frame_end;
	endsequence
	sequence s_cap1_write;
		wr && hit(paddr, tv_out_pkg::REG_CC1B);
	endsequence

	clamp_high_a: assert property (!ctrl_r[tv_out_pkg::C_KILL] && sum > 20'sd511 |-> comp == 9'h1FF)
		else $error("composite sum wrapped above range");
	kill_comp_a: assert property (ctrl_r[tv_out_pkg::C_KILL] && ctrl_r[tv_out_pkg::C_OSEL] &&
		!ctrl_r[tv_out_pkg::C_DDIS + 2] |=> dac.code[2] == $past(comp_l))
		else $error("colour kill left chroma in composite");
	prio_cc_a: assert property (st_r == tv_out_pkg::ST_IDLE && line_start && cc_hit
		|=> cc_mode_r && st_r == tv_out_pkg::ST_WAIT)
		else $error("caption lost priority on shared line");
	new_on_b_a: assert property (s_cap1_write |=> new_r[0])
		else $error("caption bytes not marked new");
	overrun_a: assert property (s_cap1_write and new_r[0] |=> ov_r[0] [*2])
		else $error("caption overrun not flagged");
	null_fill_a: assert property (consume && !new_r[fld_r]
		|=> sh_r[18:0] == {tv_out_pkg::NULL_ODD, tv_out_pkg::NULL_ODD, tv_out_pkg::START_SEQ})
		else $error("null characters not loaded");
	cg_ref_a: assert property (win_go && !cc_mode_r |=> sh_r[1:0] == tv_out_pkg::CG_REF)
		else $error("reference bits missing");
	shorten_a: assert property (s_short_req |=> frame_shorten && !frame_lengthen
		##1 !frame_shorten)
		else $error("shorten request not served");
	lengthen_a: assert property (s_long_req |=> frame_lengthen && (!req_r || $past(wr)))
		else $error("lengthen request not served");
	dac_neutral_a: assert property (ctrl_r[tv_out_pkg::C_DDIS + 1] && !ctrl_r[tv_out_pkg::C_OSEL]
		|=> dac.code[1] == tv_out_pkg::BLACK_CODE)
		else $error("disabled converter not black");
endmodule
`default_nettype wire

//--- verification/dac_receiver.sv
// Purpose: behavioural stand-in for the converters and the receiver's data slicer
// Assumes: codes arrive already registered on the design's clock
// Notes: channel order is not assumed; the bench asks how many channels carry a code
`timescale 1ns/1ps
`default_nettype none
module dac_receiver (
	input  wire tv_out_pkg::dac_out_t dac,
	input  wire logic [8:0]           probe,
	output logic [2:0]                hits,
	output logic                      caption_hi
);
	logic [2:0] hi_cnt;

	// Luma and both composites carry the data level, so two matches mean a one
	always_comb begin
		hits   = 3'h0;
		hi_cnt = 3'h0;
		for (int i = 0; i < 4; i++) begin
			hits   = hits + 3'(dac.code[i] == probe);
			hi_cnt = hi_cnt + 3'(dac.code[i] == tv_out_pkg::IRE50_CODE);
		end
		caption_hi = (hi_cnt >= 3'h2);
	end
endmodule
`default_nettype wire

//--- verification/tv_out_encoder_tb.sv
// Purpose: self-checking bench for the TV output encoder
// Assumes: zero-wait APB slave, short VBI window set through WIN_DLY
// Notes: data bits are sampled mid-period, so accumulator jitter is tolerated
`timescale 1ns/1ps
`default_nettype none
module tv_out_encoder_tb;
	localparam int W = 8;
	logic                 pclk       = 1'b0;
	logic                 presetn    = 1'b0;
	logic [7:0]           paddr      = 8'h00;
	logic                 psel       = 1'b0;
	logic                 penable    = 1'b0;
	logic                 pwrite     = 1'b0;
	logic [31:0]          pwdata     = 32'h0;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	tv_out_pkg::vid_in_t  vid        = '0;
	logic                 cbcr_stb   = 1'b0;
	logic [1:0]           stb_cnt    = 2'h0;
	logic                 line_start = 1'b0;
	logic [8:0]           line_num   = 9'h000;
	logic                 field_two  = 1'b0;
	logic                 frame_end  = 1'b0;
	tv_out_pkg::dac_out_t dac;
	logic                 frame_shorten;
	logic                 frame_lengthen;
	logic [8:0]           probe      = 9'h000;
	logic [2:0]           hits;
	logic                 caption_hi;
	int                   num_errors = 0;
	int                   num_checks = 0;
	logic [31:0]          q;
	logic                 e;
	logic [31:0]          bits;
	logic [21:0]          cg_exp;
	logic [19:0]          cg_seq;

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		stb_cnt  <= stb_cnt + 2'h1;
		cbcr_stb <= (stb_cnt == 2'h3);
	end

	tv_out_encoder #(.WIN_DLY(W)) i_tv_out_encoder (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vid(vid), .cbcr_stb(cbcr_stb), .line_start(line_start),
		.line_num(line_num), .field_two(field_two), .frame_end(frame_end), .dac(dac),
		.frame_shorten(frame_shorten), .frame_lengthen(frame_lengthen)
	);

	dac_receiver i_dac_receiver (.dac(dac), .probe(probe), .hits(hits), .caption_hi(caption_hi));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check(q, exp);
	endtask

	task automatic look(input logic [8:0] code, input int n);
		probe = code;
		#1;
		check(32'(hits), 32'(n));
	endtask

	task automatic setvid(input logic [8:0] l, input logic [8:0] lt, input logic [8:0] ch);
		@(posedge pclk);
		vid.luma      <= l;
		vid.luma_trap <= lt;
		vid.chroma    <= ch;
		repeat (6) @(posedge pclk);
	endtask

	// Gap first, so a new line never starts while the last one still sends
	task automatic line(input logic [8:0] ln, input logic f2);
		repeat (60) @(posedge pclk);
		line_start <= 1'b1;
		line_num   <= ln;
		field_two  <= f2;
		@(posedge pclk);
		line_start <= 1'b0;
	endtask

	task automatic grab(input int per, input int n);
		int c;
		c = 0;
		bits = 32'h0;
		for (int k = 0; k < n; k++) begin
			while (c < W + 2 + (k * per + per / 2) / 100) begin
				@(posedge pclk);
				c++;
			end
			#1;
			bits[k] = caption_hi;
		end
	endtask

	task automatic frame(input logic dir);
		wr(tv_out_pkg::REG_ADJ, {30'h0, dir, 1'b1});
		rd(tv_out_pkg::REG_STAT, 32'h4);
		@(posedge pclk);
		frame_end <= 1'b1;
		@(posedge pclk);
		frame_end <= 1'b0;
		#1;
		check(32'({frame_shorten, frame_lengthen}), 32'({dir, ~dir}));
		@(posedge pclk);
		#1;
		check(32'({frame_shorten, frame_lengthen}), 32'h0);
		rd(tv_out_pkg::REG_STAT, 32'h0);
	endtask

	task automatic cap(input logic [7:0] b1, input logic [7:0] b2);
		grab(4965, 26);
		check(32'(bits[25:7]), 32'({b2, b1, 3'h4}));
	endtask

	initial begin
		repeat (40000) @(posedge pclk);
		num_errors++;
		complete_run;
	end

	initial begin
		vid.cr = 8'h80;
		vid.cb = 8'h80;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(tv_out_pkg::REG_CTRL, 32'(tv_out_pkg::CTRL_RST));
		rd(tv_out_pkg::REG_CCL1, 32'(tv_out_pkg::CCL1_RST));
		rd(tv_out_pkg::REG_CCL2, 32'(tv_out_pkg::CCL2_RST));
		apb(8'hFC, 1'b0, 32'h0);
		check(32'(e), 32'h1);
		check(q, 32'h0);
		setvid(9'h1F0, 9'h1F0, 9'h064);
		look(9'h1FF, 2);
		setvid(9'h010, 9'h010, 9'h19C);
		look(9'h000, 2);
		wr(tv_out_pkg::REG_CTRL, 32'h2C);
		setvid(9'h100, 9'h0C0, 9'h032);
		look(9'h0C0, 2);
		look(9'h132, 1);
		wr(tv_out_pkg::REG_CTRL, 32'h0);
		setvid(9'h150, 9'h150, 9'h020);
		look(9'h170, 1);
		look(9'h150, 3);
		wr(tv_out_pkg::REG_CTRL, 32'h8);
		repeat (4) @(posedge pclk);
		look(9'h170, 2);
		wr(tv_out_pkg::REG_CTRL, 32'hF08);
		repeat (4) @(posedge pclk);
		look(tv_out_pkg::BLANK_CODE, 3);
		look(tv_out_pkg::CZERO_CODE, 1);
		wr(tv_out_pkg::REG_CTRL, 32'hF00);
		repeat (4) @(posedge pclk);
		look(tv_out_pkg::BLACK_CODE, 3);
		look(tv_out_pkg::BLANK_CODE, 1);
		frame(1'b1);
		frame(1'b0);
		// Caption lines, field one on its reset line
		wr(tv_out_pkg::REG_CTRL, 32'h9);
		setvid(9'h080, 9'h080, 9'h000);
		wr(tv_out_pkg::REG_CC1A, 32'h41);
		wr(tv_out_pkg::REG_CC1B, 32'h96);
		line(9'h015, 1'b0);
		fork
			cap(8'h41, 8'h96);
			begin
				repeat (100) @(posedge pclk);
				wr(tv_out_pkg::REG_CC1A, 32'h55);
			end
		join
		line(9'h015, 1'b0);
		cap(8'h80, 8'h80);
		wr(tv_out_pkg::REG_CC1B, 32'h3C);
		line(9'h015, 1'b0);
		cap(8'h55, 8'h3C);
		repeat (40) @(posedge pclk);
		wr(tv_out_pkg::REG_CC1B, 32'h11);
		wr(tv_out_pkg::REG_CC1B, 32'h22);
		rd(tv_out_pkg::REG_STAT, 32'h1);
		wr(tv_out_pkg::REG_STAT, 32'h3);
		rd(tv_out_pkg::REG_STAT, 32'h0);
		// Field two on a moved line
		wr(tv_out_pkg::REG_CCL2, 32'h120);
		wr(tv_out_pkg::REG_CTRL, 32'hB);
		wr(tv_out_pkg::REG_CC2A, 32'h01);
		wr(tv_out_pkg::REG_CC2B, 32'hFE);
		line(9'h120, 1'b1);
		cap(8'h01, 8'hFE);
		// Copy data in field two, caption of field two off
		wr(tv_out_pkg::REG_CTRL, 32'h19);
		wr(tv_out_pkg::REG_CGA, 32'h5);
		wr(tv_out_pkg::REG_CGB, 32'hA3);
		wr(tv_out_pkg::REG_CGC, 32'h3C);
		cg_seq = {4'h5, 8'hA3, 8'h3C};
		cg_exp[0] = 1'b1;
		cg_exp[1] = 1'b0;
		for (int i = 1; i <= 20; i++) cg_exp[1 + i] = cg_seq[20 - i];
		line(tv_out_pkg::CG_LINE2, 1'b1);
		grab(5587, 22);
		check(32'(bits[21:0]), 32'(cg_exp));
		// A partial load after the last register must not reach the line
		wr(tv_out_pkg::REG_CGC, 32'h3C);
		wr(tv_out_pkg::REG_CGA, 32'hA);
		line(tv_out_pkg::CG_LINE2, 1'b1);
		grab(5587, 22);
		check(32'(bits[21:0]), 32'(cg_exp));
		// Caption moved onto the copy line wins it
		wr(tv_out_pkg::REG_CC1A, 32'h12);
		wr(tv_out_pkg::REG_CC1B, 32'h34);
		wr(tv_out_pkg::REG_CCL1, 32'h014);
		line(tv_out_pkg::CG_LINE1, 1'b0);
		cap(8'h12, 8'h34);
		complete_run;
	end
endmodule
`default_nettype wire
